/* sotf_pkg.sv */
// constants for the breaker-open and switch-onto-fault window logic
package sotf_pkg;
	// clock and power-system timing
	localparam int unsigned SYS_CLK_HZ = 50_000_000;
	localparam int unsigned POWER_HZ = 60;
	// longest whole number of clocks inside one power cycle (rounds down)
	localparam int unsigned CLKS_PER_CYCLE = SYS_CLK_HZ / POWER_HZ;
	localparam int TICK_W = 20;
	localparam int SET_W = 16;
	// arm delay code that switches a path off
	localparam logic [15:0] ARM_OFF = 16'hffff;
	// register byte offsets
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_DROPOUT = 5'h04;
	localparam logic [4:0] OFF_STATUS_ARM = 5'h08;
	localparam logic [4:0] OFF_CLOSEBUS_ARM = 5'h0c;
	localparam logic [4:0] OFF_WINDOW = 5'h10;
	localparam logic [4:0] OFF_STATE = 5'h14;
	localparam logic [4:0] OFF_IRQ_STATUS = 5'h18;
	localparam logic [4:0] OFF_IRQ_MASK = 5'h1c;
	// control register fields
	localparam int CTRL_SOTF_EN_BIT = 0;
	localparam int CTRL_LED_CLR_BIT = 1;
	// state register fields
	localparam int ST_OPEN_BIT = 0;
	localparam int ST_WINDOW_BIT = 1;
	localparam int ST_STATUS_PATH_BIT = 2;
	localparam int ST_CLOSEBUS_PATH_BIT = 3;
	localparam int ST_LED_BIT = 4;
	localparam int ST_ARMED_BIT = 5;
	// interrupt event bits
	localparam int IRQ_W = 3;
	localparam int EV_OPEN_BIT = 0;
	localparam int EV_WINDOW_BIT = 1;
	localparam int EV_TRIP_BIT = 2;
	// reset values of the settings
	localparam logic [15:0] RST_DROPOUT = 16'h0001;
	localparam logic [15:0] RST_WINDOW = 16'h001e;
	localparam logic [15:0] RST_ARM = 16'hffff;
endpackage : sotf_pkg

/* timer_if.sv */
// interface between the top logic and its cycle timers
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
	logic in_lvl; // qualifying input level
	logic tick; // one clock per power cycle
	logic [15:0] set_a; // pickup or duration, in cycles
	logic [15:0] set_b; // dropout, in cycles
	logic out_lvl; // timer output
	modport timer (input in_lvl, input tick, input set_a, input set_b, output out_lvl);
	modport user (output in_lvl, output tick, output set_a, output set_b, input out_lvl);
endinterface : timer_if
`default_nettype wire

/* pudo_timer.sv */
// pickup and dropout timer counted in power cycles
`timescale 1ns/1ps
`default_nettype none
module pudo_timer (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	timer_if.timer t
);
	logic [15:0] cnt_q; // cycles spent away from the output level
	logic out_q; // timer output
	logic differ; // input disagrees with output
	logic [15:0] limit; // count needed for a change
	assign differ = t.in_lvl != out_q;
	assign limit = out_q ? t.set_b : t.set_a;
	assign t.out_lvl = out_q;
	// count while input differs, restart at once when it agrees again
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || !differ) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q >= limit) begin
			cnt_q <= 16'h0000;
		end else if (t.tick) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
	// output follows input once the count is reached
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			out_q <= 1'b0;
		end else if (differ && cnt_q >= limit) begin
			out_q <= t.in_lvl;
		end
	end
endmodule : pudo_timer
`default_nettype wire

/* window_oneshot.sv */
// rising-edge one-shot that holds for a set number of power cycles
`timescale 1ns/1ps
`default_nettype none
module window_oneshot (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	timer_if.timer t
);
	logic prev_q; // input one clock ago
	logic busy_q; // window running
	logic [15:0] cnt_q; // cycles elapsed in the window
	logic rise; // rising edge on the input
	assign rise = t.in_lvl && !prev_q;
	assign t.out_lvl = busy_q;
	// edge detector
	always_ff @(posedge clk_sys_i) begin
		prev_q <= sys_rst_i ? 1'b0 : t.in_lvl;
	end
	// start on an edge only when idle, new edges ignored while timing
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			busy_q <= 1'b0;
			cnt_q <= 16'h0000;
		end else if (!busy_q) begin
			busy_q <= rise;
			cnt_q <= 16'h0000;
		end else if (cnt_q >= t.set_a) begin
			busy_q <= 1'b0;
		end else if (t.tick) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
endmodule : window_oneshot
`default_nettype wire

/* sotf_logic.sv */
// breaker-open flag, switch-onto-fault window and register slave
//
// Functional notes
// - flag set: status low, no load current
// - flag clears only after dropout delay
// - sotf enable never touches the flag
// - status tied low: load detect alone
// - flag feeds overreach scheme and potential-loss
// - status path: flag held arm delay
// - status path holds window after flag drops
// - close-bus arm: no load for delay
// - close-bus monitor ANDed with arm output
// - window one-shot ignores edges while timing
// - window output ORs both paths
// - trip only with element and window
// - sotf trip lights the front indicator
`timescale 1ns/1ps
`default_nettype none
module sotf_logic #(
	parameter int unsigned CLKS_PER_CYCLE = sotf_pkg::CLKS_PER_CYCLE
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// protection inputs
	input wire logic breaker_status_input_i,
	input wire logic load_current_detect_i,
	input wire logic closebus_monitor_input_i,
	input wire logic sotf_trip_equation_i,
	// protection outputs
	output logic breaker_open_flag_o,
	output logic permissive_overreach_scheme_open_o,
	output logic potential_loss_logic_open_o,
	output logic sotf_window_output_o,
	output logic sotf_trip_o,
	output logic sotf_led_o,
	output logic irq_o
);
	// merge written byte lanes into a register value
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wr,
			input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wr[i*8 +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// settings registers
	logic sotf_enable_setting_q; // kept for software, no effect on the flag
	logic [15:0] open_flag_dropout_delay_q; // flag dropout, cycles
	logic [15:0] status_path_arm_delay_q; // status path arming, cycles or off
	logic [15:0] closebus_path_arm_delay_q; // close-bus arming, cycles or off
	logic [15:0] sotf_window_duration_q; // window length, cycles
	logic [sotf_pkg::IRQ_W-1:0] irq_status_q; // sticky events
	logic [sotf_pkg::IRQ_W-1:0] irq_mask_q; // event enables

	// power-cycle tick generation
	localparam logic [sotf_pkg::TICK_W-1:0] TICK_LAST =
		sotf_pkg::TICK_W'(CLKS_PER_CYCLE - 1);
	logic [sotf_pkg::TICK_W-1:0] tick_cnt_q; // clocks into the cycle
	logic tick_q; // one clock per power cycle

	// output registers
	logic open_q; // registered flag copy
	logic window_q; // registered window
	logic trip_q; // registered trip
	logic led_q; // latched indicator
	logic irq_q; // registered interrupt
	logic ack_q; // bus acknowledge
	logic [31:0] dat_q; // bus read data

	// bus decode
	logic bus_req; // new access this clock
	logic bus_wr; // new write this clock
	logic [31:0] rd_mux; // read data selected by address
	logic [31:0] ctrl_wr; // merged control word
	logic led_clr; // software clears the indicator
	logic [31:0] state_word; // live state readback
	logic [31:0] dropout_wr; // dropout word after lane merge
	logic [31:0] status_arm_wr; // status arm word after lane merge
	logic [31:0] closebus_arm_wr; // close-bus arm word after lane merge
	logic [31:0] window_wr; // window word after lane merge
	logic [31:0] mask_wr; // mask word after lane merge
	logic [31:0] clr_wr; // clear bits after lane merge

	// timer interfaces
	timer_if open_t ();
	timer_if status_arm_t ();
	timer_if closebus_arm_t ();
	timer_if status_win_t ();
	timer_if closebus_win_t ();

	// path control
	logic raw_open; // instantaneous open condition
	logic status_en; // status path armed delay is not off
	logic closebus_en; // close-bus path armed delay is not off
	logic status_path; // status path contribution
	logic closebus_path; // close-bus path contribution
	logic window_d; // combined window
	logic trip_d; // trip permission
	logic [sotf_pkg::IRQ_W-1:0] ev; // events this clock
	logic [sotf_pkg::IRQ_W-1:0] ev_lvl; // levels behind the events
	logic [sotf_pkg::IRQ_W-1:0] ev_prev_q; // levels one clock ago
	logic [sotf_pkg::IRQ_W-1:0] irq_clr; // write-one-to-clear bits

	// tick divider, free running
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || tick_cnt_q == TICK_LAST) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	// one tick at the end of each cycle
	always_ff @(posedge clk_sys_i) begin
		tick_q <= !sys_rst_i && tick_cnt_q == TICK_LAST;
	end

	// open when no status, no load
	// status tied low leaves load alone
	assign raw_open = !breaker_status_input_i && !load_current_detect_i;

	assign open_t.in_lvl = raw_open;
	assign open_t.tick = tick_q;
	assign open_t.set_a = 16'h0000;
	assign open_t.set_b = open_flag_dropout_delay_q;
	pudo_timer open_tmr (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.t(open_t)
	);

	// paths are live only when their arm delay is not off
	assign status_en = status_path_arm_delay_q != sotf_pkg::ARM_OFF;
	assign closebus_en = closebus_path_arm_delay_q != sotf_pkg::ARM_OFF;

	assign status_arm_t.in_lvl = open_t.out_lvl && status_en;
	assign status_arm_t.tick = tick_q;
	assign status_arm_t.set_a = status_path_arm_delay_q;
	assign status_arm_t.set_b = 16'h0000;
	pudo_timer status_arm_tmr (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.t(status_arm_t)
	);

	assign status_win_t.in_lvl = status_arm_t.out_lvl;
	assign status_win_t.tick = tick_q;
	assign status_win_t.set_a = 16'h0000;
	assign status_win_t.set_b = sotf_window_duration_q;
	pudo_timer status_win_tmr (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.t(status_win_t)
	);
	// a path switched off contributes nothing at once
	assign status_path = status_win_t.out_lvl && status_en;

	assign closebus_arm_t.in_lvl = !load_current_detect_i && closebus_en;
	assign closebus_arm_t.tick = tick_q;
	assign closebus_arm_t.set_a = closebus_path_arm_delay_q;
	assign closebus_arm_t.set_b = 16'h0000;
	pudo_timer closebus_arm_tmr (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.t(closebus_arm_t)
	);

	assign closebus_win_t.in_lvl = closebus_monitor_input_i && closebus_arm_t.out_lvl;
	assign closebus_win_t.tick = tick_q;
	assign closebus_win_t.set_a = sotf_window_duration_q;
	assign closebus_win_t.set_b = 16'h0000;
	window_oneshot closebus_win_tmr (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.t(closebus_win_t)
	);
	assign closebus_path = closebus_win_t.out_lvl && closebus_en;

	assign window_d = status_path || closebus_path;
	assign trip_d = sotf_trip_equation_i && window_d;

	// protection outputs, all registered
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			open_q <= 1'b0;
			window_q <= 1'b0;
			trip_q <= 1'b0;
		end else begin
			open_q <= open_t.out_lvl;
			window_q <= window_d;
			trip_q <= trip_d;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			led_q <= 1'b0;
		end else if (trip_d) begin
			led_q <= 1'b1;
		end else if (led_clr) begin
			led_q <= 1'b0;
		end
	end

	assign breaker_open_flag_o = open_q;
	assign permissive_overreach_scheme_open_o = open_q;
	assign potential_loss_logic_open_o = open_q;
	assign sotf_window_output_o = window_q;
	assign sotf_trip_o = trip_q;
	assign sotf_led_o = led_q;

	// event rising edges
	assign ev_lvl[sotf_pkg::EV_OPEN_BIT] = open_t.out_lvl;
	assign ev_lvl[sotf_pkg::EV_WINDOW_BIT] = window_d;
	assign ev_lvl[sotf_pkg::EV_TRIP_BIT] = trip_d;
	assign ev = ev_lvl & ~ev_prev_q;

	// event level history
	always_ff @(posedge clk_sys_i) begin
		ev_prev_q <= sys_rst_i ? '0 : ev_lvl;
	end

	// bus access decode
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
	assign bus_wr = bus_req && wb_we_i;
	assign ctrl_wr = lane_merge({31'h0, sotf_enable_setting_q}, wb_dat_i, wb_sel_i);
	assign led_clr = bus_wr && wb_adr_i == sotf_pkg::OFF_CTRL &&
		ctrl_wr[sotf_pkg::CTRL_LED_CLR_BIT];
	// merged words as named wires, a function result cannot be sliced
	assign dropout_wr = lane_merge({16'h0, open_flag_dropout_delay_q}, wb_dat_i, wb_sel_i);
	assign status_arm_wr = lane_merge({16'h0, status_path_arm_delay_q}, wb_dat_i, wb_sel_i);
	assign closebus_arm_wr = lane_merge({16'h0, closebus_path_arm_delay_q}, wb_dat_i, wb_sel_i);
	assign window_wr = lane_merge({16'h0, sotf_window_duration_q}, wb_dat_i, wb_sel_i);
	assign mask_wr = lane_merge({29'h0, irq_mask_q}, wb_dat_i, wb_sel_i);
	assign clr_wr = lane_merge(32'h0, wb_dat_i, wb_sel_i);
	assign irq_clr = (bus_wr && wb_adr_i == sotf_pkg::OFF_IRQ_STATUS) ?
		clr_wr[sotf_pkg::IRQ_W-1:0] : '0;

	// sticky status, a new event beats a clear
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= (irq_status_q & ~irq_clr) | ev;
		end
	end

	// level interrupt from unmasked status
	always_ff @(posedge clk_sys_i) begin
		irq_q <= !sys_rst_i && |(irq_status_q & irq_mask_q);
	end
	assign irq_o = irq_q;

	// settings writes
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sotf_enable_setting_q <= 1'b0;
			open_flag_dropout_delay_q <= sotf_pkg::RST_DROPOUT;
			status_path_arm_delay_q <= sotf_pkg::RST_ARM;
			closebus_path_arm_delay_q <= sotf_pkg::RST_ARM;
			sotf_window_duration_q <= sotf_pkg::RST_WINDOW;
			irq_mask_q <= '0;
		end else if (bus_wr) begin
			unique case (wb_adr_i)
				sotf_pkg::OFF_CTRL: begin
					sotf_enable_setting_q <= ctrl_wr[sotf_pkg::CTRL_SOTF_EN_BIT];
				end
				sotf_pkg::OFF_DROPOUT: begin
					open_flag_dropout_delay_q <= dropout_wr[15:0];
				end
				sotf_pkg::OFF_STATUS_ARM: begin
					status_path_arm_delay_q <= status_arm_wr[15:0];
				end
				sotf_pkg::OFF_CLOSEBUS_ARM: begin
					closebus_path_arm_delay_q <= closebus_arm_wr[15:0];
				end
				sotf_pkg::OFF_WINDOW: begin
					sotf_window_duration_q <= window_wr[15:0];
				end
				sotf_pkg::OFF_IRQ_MASK: begin
					irq_mask_q <= mask_wr[sotf_pkg::IRQ_W-1:0];
				end
				default: begin
					// read-only or unmapped, ignored
				end
			endcase
		end
	end

	// live state word
	assign state_word = {26'h0, status_arm_t.out_lvl, led_q, closebus_path, status_path,
		window_d, open_t.out_lvl};

	// read data selection, unmapped reads zero
	assign rd_mux =
		(wb_adr_i == sotf_pkg::OFF_CTRL) ? {31'h0, sotf_enable_setting_q} :
		(wb_adr_i == sotf_pkg::OFF_DROPOUT) ? {16'h0, open_flag_dropout_delay_q} :
		(wb_adr_i == sotf_pkg::OFF_STATUS_ARM) ? {16'h0, status_path_arm_delay_q} :
		(wb_adr_i == sotf_pkg::OFF_CLOSEBUS_ARM) ? {16'h0, closebus_path_arm_delay_q} :
		(wb_adr_i == sotf_pkg::OFF_WINDOW) ? {16'h0, sotf_window_duration_q} :
		(wb_adr_i == sotf_pkg::OFF_STATE) ? state_word :
		(wb_adr_i == sotf_pkg::OFF_IRQ_STATUS) ? {29'h0, irq_status_q} :
		(wb_adr_i == sotf_pkg::OFF_IRQ_MASK) ? {29'h0, irq_mask_q} :
		32'h0000_0000;

	// one-clock acknowledge with registered data
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req;
			dat_q <= bus_req ? rd_mux : 32'h0000_0000;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
endmodule : sotf_logic
`default_nettype wire

/* sotf_logic_assertions.sv */
// checker for the breaker-open flag, window and bus timing
`timescale 1ns/1ps
`default_nettype none
module sotf_logic_checker #(
	parameter int unsigned CLKS_PER_CYCLE = 4
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic breaker_status_input_i,
	input wire logic load_current_detect_i,
	input wire logic sotf_trip_equation_i,
	input wire logic breaker_open_flag_o,
	input wire logic permissive_overreach_scheme_open_o,
	input wire logic potential_loss_logic_open_o,
	input wire logic sotf_window_output_o,
	input wire logic sotf_trip_o,
	input wire logic sotf_led_o
);
	// raw open: contact open and no load current
	wire raw_open = !breaker_status_input_i && !load_current_detect_i;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	flag_set_a: assert property (raw_open [*4] |-> breaker_open_flag_o)
		else $error("open flag missing while breaker open");
	flag_drop_a: assert property ($fell(breaker_open_flag_o) |->
		!$past(raw_open, 2)) else $error("open flag dropped early");
	flag_copies_a: assert property ((permissive_overreach_scheme_open_o ==
		potential_loss_logic_open_o) && (potential_loss_logic_open_o == breaker_open_flag_o
		|| potential_loss_logic_open_o == $past(breaker_open_flag_o))) else $error("flag copy");
	trip_cause_a: assert property (sotf_trip_o |-> $past(sotf_trip_equation_i))
		else $error("trip without element");
	trip_window_a: assert property (sotf_trip_o |->
		sotf_window_output_o || $past(sotf_window_output_o)) else $error("trip outside window");
	led_on_a: assert property (sotf_trip_o |-> ##[0:2] sotf_led_o)
		else $error("indicator not lit on trip");
	window_hold_a: assert property ($rose(sotf_window_output_o) |=>
		sotf_window_output_o [*8]) else $error("window too short");
	ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus access not acknowledged");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero while idle");
endmodule : sotf_logic_checker
bind sotf_logic sotf_logic_checker #(.CLKS_PER_CYCLE(CLKS_PER_CYCLE)) u_chk (
	.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .breaker_status_input_i(breaker_status_input_i),
	.load_current_detect_i(load_current_detect_i), .sotf_window_output_o(sotf_window_output_o),
	.sotf_trip_equation_i(sotf_trip_equation_i), .breaker_open_flag_o(breaker_open_flag_o),
	.permissive_overreach_scheme_open_o(permissive_overreach_scheme_open_o),
	.potential_loss_logic_open_o(potential_loss_logic_open_o),
	.sotf_trip_o(sotf_trip_o), .sotf_led_o(sotf_led_o));
`default_nettype wire

/* breaker_model.sv */
// far side: breaker contact, close bus and trip element
`timescale 1ns/1ps
`default_nettype none
module breaker_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic close_i,
	input wire logic open_i,
	input wire logic fault_i,
	input wire logic aux_tied_i,
	input wire logic [3:0] lag_i,
	output logic status_o,
	output logic load_o,
	output logic bus_o,
	output logic element_o
);
	logic closed_q; // main contacts made
	logic bus_q; // close bus energized
	logic [3:0] cnt_q; // contact travel countdown
	// close bus stays up until contacts make; lag models a slow breaker
	always_ff @(posedge clk_i) begin
		if (rst_i || open_i) begin
			closed_q <= 1'b0;
			bus_q <= 1'b0;
		end else if (close_i && !closed_q && !bus_q) begin
			bus_q <= 1'b1;
			cnt_q <= lag_i;
		end else if (bus_q) begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h0) begin
				closed_q <= 1'b1;
				bus_q <= 1'b0;
			end
		end
	end
	assign status_o = closed_q && !aux_tied_i;
	assign load_o = closed_q; // load flows once closed
	assign bus_o = bus_q;
	assign element_o = fault_i; // fault element level
endmodule : breaker_model
`default_nettype wire

/* sotf_logic_bench.sv */
// self-checking bench for the breaker-open and window logic
`timescale 1ns/1ps
`default_nettype none
module sotf_logic_bench;
	localparam int unsigned CPC = 4; // clocks per power cycle, shortened
	localparam logic [38:0] ALL = 39'h00ffffffff; // whole data word
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [4:0] wb_adr_i = 5'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wb_ack_o, st, ld, cb, te, flag, pos, pll, win, trip, led, irq;
	logic close_c = 1'b0, open_c = 1'b0, fault_c = 1'b0, tied_c = 1'b0; // model commands
	logic [3:0] lag_c = 4'h0; // close travel time
	logic [38:0] mask_q[$], exp_q[$]; // pending read notes
	logic trip_seen = 1'b0; // trip pin pulsed since the last read
	int num_errors = 0, comparisons = 0, cycles = 0;
	integer seed = 32'h95759d24;
	sotf_logic #(.CLKS_PER_CYCLE(CPC)) u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.breaker_status_input_i(st), .load_current_detect_i(ld), .closebus_monitor_input_i(cb),
		.sotf_trip_equation_i(te), .breaker_open_flag_o(flag),
		.permissive_overreach_scheme_open_o(pos), .potential_loss_logic_open_o(pll),
		.sotf_window_output_o(win), .sotf_trip_o(trip), .sotf_led_o(led), .irq_o(irq));
	breaker_model u_brk (.clk_i(clk_sys_i), .rst_i(sys_rst_i), .close_i(close_c),
		.open_i(open_c), .fault_i(fault_c), .aux_tied_i(tied_c), .lag_i(lag_c),
		.status_o(st), .load_o(ld), .bus_o(cb), .element_o(te));
	initial forever #10 clk_sys_i = ~clk_sys_i;
	task automatic check(input logic [38:0] seen, input logic [38:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t read mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results;
		$display("counts: %0d mismatches, %0d comparisons", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : wt
	// one classic access, held until ack is sampled
	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		@(posedge clk_sys_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_sys_i);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus
	task automatic rd(input logic [4:0] a, input logic [38:0] e, input logic [38:0] m);
		mask_q.push_back(m);
		exp_q.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask : rd
	task automatic stat(input logic [5:0] e, input logic [5:0] m);
		// pins above irq: trip seen and led share bit 4, window, three flag copies
		rd(sotf_pkg::OFF_STATE, {e[4], e[4], e[1], {3{e[0]}}, 1'b0, 26'h0, e},
			{m[4], m[4], m[1], {3{m[0]}}, 1'b0, 26'h0, m});
	endtask : stat
	// pulse a close or an open command to the breaker
	task automatic brk(input logic c);
		@(posedge clk_sys_i);
		if (c) close_c <= 1'b1;
		else open_c <= 1'b1;
		@(posedge clk_sys_i);
		close_c <= 1'b0;
		open_c <= 1'b0;
	endtask : brk
	task automatic zap;
		@(posedge clk_sys_i);
		fault_c <= 1'b1;
		wt(3);
		fault_c <= 1'b0;
	endtask : zap
	// compare each read answer, irq and output pins above it, with the oldest note
	always @(posedge clk_sys_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			check({trip_seen, led, win, pll, pos, flag, irq, wb_dat_o} & mask_q[0],
				exp_q[0] & mask_q[0]);
			void'(mask_q.pop_front());
			void'(exp_q.pop_front());
			trip_seen = 1'b0;
		end
		if (trip === 1'b1) begin
			trip_seen = 1'b1;
		end
	end
	// hang guard
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 10000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		wt(6);
		sys_rst_i <= 1'b0;
		rd(sotf_pkg::OFF_CTRL, 39'h0, ALL);
		rd(sotf_pkg::OFF_DROPOUT, 39'h1, ALL);
		rd(sotf_pkg::OFF_STATUS_ARM, 39'hffff, ALL);
		rd(sotf_pkg::OFF_CLOSEBUS_ARM, 39'hffff, ALL);
		rd(sotf_pkg::OFF_WINDOW, 39'h1e, ALL);
		rd(sotf_pkg::OFF_IRQ_MASK, 39'h0, ALL);
		$display("reset values done");
		bus(sotf_pkg::OFF_STATE, 1'b1, $random(seed)); // read-only place
		for (int i = 0; i < 2; i++) begin
			bus(sotf_pkg::OFF_CTRL, 1'b1, 32'(i));
			stat(6'h01, 6'h01);
		end
		$display("open flag done");
		bus(sotf_pkg::OFF_DROPOUT, 1'b1, 32'h3);
		for (int t = 1; t >= 0; t--) begin
			tied_c <= t[0];
			brk(1'b1);
			wt(2);
			stat(6'h01, 6'h01);
			wt(20);
			stat(6'h00, 6'h01);
			brk(1'b0);
			wt(4);
		end
		$display("dropout done");
		brk(1'b1);
		wt(8);
		bus(sotf_pkg::OFF_DROPOUT, 1'b1, 32'h1);
		bus(sotf_pkg::OFF_STATUS_ARM, 1'b1, 32'h5);
		stat(6'h00, 6'h02);
		brk(1'b0);
		wt(4);
		stat(6'h01, 6'h03);
		wt(30);
		stat(6'h27, 6'h2f);
		brk(1'b1);
		wt(40);
		stat(6'h06, 6'h07);
		zap();
		wt(2);
		stat(6'h10, 6'h10);
		wt(100);
		stat(6'h00, 6'h02);
		bus(sotf_pkg::OFF_CTRL, 1'b1, 32'h2);
		zap();
		wt(2);
		stat(6'h00, 6'h10);
		$display("status path done");
		bus(sotf_pkg::OFF_STATUS_ARM, 1'b1, 32'hffff);
		bus(sotf_pkg::OFF_CLOSEBUS_ARM, 1'b1, 32'h3);
		brk(1'b0);
		wt(20);
		stat(6'h00, 6'h0e);
		lag_c <= 4'($random(seed));
		brk(1'b1);
		wt(24);
		stat(6'h0a, 6'h0e);
		brk(1'b0);
		wt(24);
		brk(1'b1);
		wt(85);
		stat(6'h00, 6'h0a);
		lag_c <= 4'h0;
		for (int k = 0; k < 2; k++) begin
			brk(1'b0);
			wt(2);
			brk(1'b1);
		end
		wt(10);
		stat(6'h00, 6'h0a);
		$display("close bus path done");
		bus(sotf_pkg::OFF_IRQ_MASK, 1'b1, 32'h4);
		wt(2);
		rd(sotf_pkg::OFF_IRQ_STATUS, 39'h0100000004, 39'h0100000004);
		bus(sotf_pkg::OFF_IRQ_MASK, 1'b1, 32'h0);
		wt(2);
		rd(sotf_pkg::OFF_IRQ_STATUS, 39'h0000000004, 39'h0100000004);
		bus(sotf_pkg::OFF_IRQ_STATUS, 1'b1, 32'h4);
		bus(sotf_pkg::OFF_IRQ_MASK, 1'b1, 32'h4);
		wt(2);
		rd(sotf_pkg::OFF_IRQ_STATUS, 39'h0, 39'h0100000004);
		$display("interrupt done");
		results();
	end
endmodule : sotf_logic_bench
`default_nettype wire
